// File: iwo_timer.sv
// Chosen here: the AXI4-Lite register port and the register addresses.
`timescale 1ns/1ps
// Summary of operation
// - Writing start trigger sets enable status and waits for a start edge.
// - Start edge loads counter from data register (FFFF) and counts down.
// - Stop edge halts counter, keeps value, waits for next start.
// - Later start edges reload FFFF and resume counting down.
// - Counter reaching 0000 before stop edge raises the channel interrupt.
// - After reaching zero the counter rests at FFFF awaiting a start.
// - Edge select 10 measures low width: falling starts, rising stops.
// - Edge select 11 measures high width: rising starts, falling stops.
// - Start edges during counting are ignored.
// - Clock select 00..11 picks one of four prescaled operation clocks.
// - Count clock source 0 counts on the selected operation clock.
// - Trigger source 010 uses input valid edge as start, reverse as stop.
// - Operating mode 0100 runs the channel in one-count mode.
// - Start interrupt control 0 raises no interrupt at operation start.
// - Start trigger bit clears itself after a write of one.
// - Stop trigger clears enable status and halts counter at its value.
// - Counter is readable at any time without disturbing counting.
// - Timer output pin is unused in this function.
module iwo_timer
  import iwo_pkg::*;
(
  input wire logic clk_i, // 25 MHz system clock.
  input wire logic rst_n_i, // Synchronous reset, active low.
  input wire logic ce_i, // Clock enable, freezes all state when low.
  input wire logic [7:0] s_axi_awaddr, // Write address.
  input wire logic s_axi_awvalid, // Write address valid.
  output logic s_axi_awready, // Write address ready.
  input wire logic [31:0] s_axi_wdata, // Write data.
  input wire logic [3:0] s_axi_wstrb, // Write byte strobes.
  input wire logic s_axi_wvalid, // Write data valid.
  output logic s_axi_wready, // Write data ready.
  output logic [1:0] s_axi_bresp, // Write response.
  output logic s_axi_bvalid, // Write response valid.
  input wire logic s_axi_bready, // Write response ready.
  input wire logic [7:0] s_axi_araddr, // Read address.
  input wire logic s_axi_arvalid, // Read address valid.
  output logic s_axi_arready, // Read address ready.
  output logic [31:0] s_axi_rdata, // Read data.
  output logic [1:0] s_axi_rresp, // Read response.
  output logic s_axi_rvalid, // Read data valid.
  input wire logic s_axi_rready, // Read data ready.
  input wire logic timer_input_i, // Monitored input pulse.
  output logic timer_output_pin_o, // Channel output, unused here.
  output logic channel_interrupt_o // One-cycle interrupt pulse.
);
  logic [15:0] channel_mode_config_reg;
  logic [1:0] input_edge_select_reg;
  logic [15:0] channel_data_register_reg;
  logic [15:0] channel_counter_reg;
  logic [15:0] presc_reg;
  logic channel_enable_status_reg;
  logic irq_reg;
  iwo_state_t state_reg;

  logic [7:0] aw_addr_reg;
  logic aw_held_reg;
  logic [31:0] w_data_reg;
  logic [3:0] w_strb_reg;
  logic w_held_reg;
  logic bvalid_reg;
  logic [1:0] bresp_reg;
  logic rvalid_reg;
  logic [31:0] rdata_reg;
  logic [1:0] rresp_reg;

  logic [3:0] tick;
  logic op_tick;
  logic rise;
  logic fall;
  logic start_edge;
  logic stop_edge;
  logic wr_fire;
  logic rd_fire;
  logic start_trig;
  logic stop_trig;
  logic wr_hit;
  logic [15:0] wr_lo;

  logic [1:0] cks;
  logic count_clock_source;
  logic [2:0] sts;
  logic [3:0] md;
  logic md0;
  logic mode_ok;
  logic [1:0] status_bits;

  assign cks = channel_mode_config_reg[MODE_CKS_LSB +: 2];
  assign count_clock_source = channel_mode_config_reg[MODE_COUNT_CLOCK_SOURCE_BIT];
  assign sts = channel_mode_config_reg[MODE_STS_LSB +: 3];
  assign md = channel_mode_config_reg[MODE_MD_LSB +: 4];
  assign md0 = channel_mode_config_reg[MODE_MD0_BIT];
  // Only the one-count, input-triggered configuration counts; other settings stay idle.
  assign mode_ok = (md == MD_ONE_COUNT) && (sts == STS_INPUT_EDGE) && !count_clock_source;

  iwo_prescaler u_presc (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .ce_i(ce_i),
    .presc_i(presc_reg),
    .tick_o(tick)
  );

  assign op_tick = tick[cks];

  iwo_edge_detect u_edge (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .ce_i(ce_i),
    .tick_i(op_tick),
    .timer_input_i(timer_input_i),
    .rise_o(rise),
    .fall_o(fall)
  );

  // Codes 00 and 01 select no edges, so a started channel simply waits.
  always_comb begin
    case (input_edge_select_reg)
      EDGE_LOW_WIDTH: begin
        start_edge = op_tick && fall;
        stop_edge = op_tick && rise;
      end
      EDGE_HIGH_WIDTH: begin
        start_edge = op_tick && rise;
        stop_edge = op_tick && fall;
      end
      default: begin
        start_edge = 1'b0;
        stop_edge = 1'b0;
      end
    endcase
  end

  // Write path: address and data are caught independently, in either order.
  // Ready stays low while the clock enable is low, so no handshake completes on a frozen edge.
  assign s_axi_awready = ce_i && !aw_held_reg && !bvalid_reg;
  assign s_axi_wready = ce_i && !w_held_reg && !bvalid_reg;
  assign wr_fire = aw_held_reg && w_held_reg && !bvalid_reg && ce_i;
  assign wr_lo = {s_axi_wstrb_hi(w_strb_reg[1], w_data_reg[15:8]), s_axi_wstrb_hi(w_strb_reg[0], w_data_reg[7:0])};
  assign wr_hit = wr_fire && (w_strb_reg[1:0] != 2'h0);

  function automatic logic [7:0] s_axi_wstrb_hi(input logic en, input logic [7:0] d);
    s_axi_wstrb_hi = en ? d : 8'h00;
  endfunction

  // Byte lanes without a strobe keep the register's old contents.
  function automatic logic [15:0] merge(input logic [15:0] old, input logic [1:0] st, input logic [15:0] d);
    merge = {st[1] ? d[15:8] : old[15:8], st[0] ? d[7:0] : old[7:0]};
  endfunction

  // An unmapped word answers with an error instead of silently aliasing a register.
  function automatic logic reg_mapped(input logic [7:0] a);
    case (a)
      ADDR_MODE, ADDR_EDGE, ADDR_DATA, ADDR_CNT, ADDR_TRIG, ADDR_STAT, ADDR_PRESC: reg_mapped = 1'b1;
      default: reg_mapped = 1'b0;
    endcase
  endfunction

  // Trigger bits are write-only pulses, so they clear themselves by construction.
  assign start_trig = wr_fire && (aw_addr_reg == ADDR_TRIG) && w_strb_reg[0] && wr_lo[TRIG_START_BIT];
  assign stop_trig = wr_fire && (aw_addr_reg == ADDR_TRIG) && w_strb_reg[0] && wr_lo[TRIG_STOP_BIT];

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      aw_held_reg <= 1'b0;
      aw_addr_reg <= 8'h00;
    end else if (ce_i) begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held_reg <= 1'b1;
        aw_addr_reg <= {s_axi_awaddr[7:2], 2'h0};
      end else if (wr_fire) begin
        aw_held_reg <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      w_held_reg <= 1'b0;
      w_data_reg <= 32'h00000000;
      w_strb_reg <= 4'h0;
    end else if (ce_i) begin
      if (s_axi_wvalid && s_axi_wready) begin
        w_held_reg <= 1'b1;
        w_data_reg <= s_axi_wdata;
        w_strb_reg <= s_axi_wstrb;
      end else if (wr_fire) begin
        w_held_reg <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      bvalid_reg <= 1'b0;
      bresp_reg <= AXI_OKAY;
    end else if (ce_i) begin
      if (wr_fire) begin
        bvalid_reg <= 1'b1;
        bresp_reg <= reg_mapped(aw_addr_reg) ? AXI_OKAY : AXI_SLVERR;
      end else if (s_axi_bready) begin
        bvalid_reg <= 1'b0;
      end
    end
  end

  assign s_axi_bvalid = bvalid_reg;
  assign s_axi_bresp = bresp_reg;

  // Configuration registers.
  // Trigger, counter and status words are not stored, so writes to them change nothing here.
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      channel_mode_config_reg <= MODE_RESET;
      input_edge_select_reg <= EDGE_RESET;
      channel_data_register_reg <= DATA_RESET;
      presc_reg <= PRESC_RESET;
    end else if (ce_i && wr_hit) begin
      case (aw_addr_reg)
        ADDR_MODE: channel_mode_config_reg <= merge(channel_mode_config_reg, w_strb_reg[1:0], wr_lo & MODE_WMASK);
        ADDR_EDGE: begin
          if (w_strb_reg[0]) begin
            input_edge_select_reg <= wr_lo[1:0];
          end
        end
        ADDR_DATA: channel_data_register_reg <= merge(channel_data_register_reg, w_strb_reg[1:0], wr_lo);
        ADDR_PRESC: presc_reg <= merge(presc_reg, w_strb_reg[1:0], wr_lo);
        default: begin
        end
      endcase
    end
  end

  // Channel enable status.
  // Enable status stays set after a zero-reach; only the stop trigger clears it.
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      channel_enable_status_reg <= 1'b0;
    end else if (ce_i) begin
      if (start_trig) begin
        channel_enable_status_reg <= 1'b1;
      end else if (stop_trig) begin
        channel_enable_status_reg <= 1'b0;
      end
    end
  end

  // Counter state machine; the stop trigger halts without touching the count.
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      state_reg <= IWO_IDLE;
      channel_counter_reg <= CNT_RESET;
      irq_reg <= 1'b0;
    end else if (ce_i) begin
      irq_reg <= 1'b0;
      // A start and a stop in one write resolve to start, matching the enable status.
      if (stop_trig && !start_trig) begin
        state_reg <= IWO_IDLE;
      end else begin
        case (state_reg)
          IWO_IDLE: begin
            if (start_trig) begin
              state_reg <= IWO_WAIT;
            end
          end
          IWO_WAIT: begin
            // The mode is checked only here, so an MD, STS or count clock source change mid-count applies from the next start.
            if (start_edge && mode_ok) begin
              channel_counter_reg <= channel_data_register_reg;
              state_reg <= IWO_COUNT;
            end
          end
          IWO_COUNT: begin
            // Start edges are not examined here, so a count cannot be restarted.
            if (stop_edge) begin
              state_reg <= IWO_WAIT;
            end else if (op_tick) begin
              if (channel_counter_reg == CNT_TERMINAL) begin
                irq_reg <= 1'b1;
                channel_counter_reg <= CNT_STOP_VALUE;
                state_reg <= IWO_WAIT;
              end else begin
                channel_counter_reg <= channel_counter_reg - 16'h0001;
              end
            end
          end
          default: state_reg <= IWO_IDLE;
        endcase
      end
    end
  end

  // The interrupt is one clock wide; there is no pending flag to clear.
  assign channel_interrupt_o = irq_reg;
  assign timer_output_pin_o = 1'b0;

  // Bit 1 shows counting, bit 0 the enable status, which survives a zero-reach.
  assign status_bits = {state_reg == IWO_COUNT, channel_enable_status_reg};

  // Read path; reads have no side effects on the counter.
  // The counter is copied into the read data register, so a read never stalls counting.
  assign s_axi_arready = ce_i && !rvalid_reg;
  assign rd_fire = s_axi_arvalid && s_axi_arready && ce_i;

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      rvalid_reg <= 1'b0;
      rdata_reg <= 32'h00000000;
      rresp_reg <= AXI_OKAY;
    end else if (ce_i) begin
      if (rd_fire) begin
        rvalid_reg <= 1'b1;
        rresp_reg <= AXI_OKAY;
        case ({s_axi_araddr[7:2], 2'h0})
          ADDR_MODE: rdata_reg <= {16'h0000, channel_mode_config_reg};
          ADDR_EDGE: rdata_reg <= {30'h00000000, input_edge_select_reg};
          ADDR_DATA: rdata_reg <= {16'h0000, channel_data_register_reg};
          ADDR_CNT: rdata_reg <= {16'h0000, channel_counter_reg};
          ADDR_TRIG: rdata_reg <= 32'h00000000;
          ADDR_STAT: rdata_reg <= {30'h00000000, status_bits};
          ADDR_PRESC: rdata_reg <= {16'h0000, presc_reg};
          default: begin
            rdata_reg <= 32'h00000000;
            rresp_reg <= AXI_SLVERR;
          end
        endcase
      end else if (s_axi_rready) begin
        rvalid_reg <= 1'b0;
      end
    end
  end

  assign s_axi_rvalid = rvalid_reg;
  assign s_axi_rdata = rdata_reg;
  assign s_axi_rresp = rresp_reg;
endmodule

// File: iwo_pkg.sv
package iwo_pkg;
  // AXI4-Lite register byte addresses.
  localparam logic [7:0] ADDR_MODE = 8'h00;
  localparam logic [7:0] ADDR_EDGE = 8'h04;
  localparam logic [7:0] ADDR_DATA = 8'h08;
  localparam logic [7:0] ADDR_CNT = 8'h0C;
  localparam logic [7:0] ADDR_TRIG = 8'h10;
  localparam logic [7:0] ADDR_STAT = 8'h14;
  localparam logic [7:0] ADDR_PRESC = 8'h18;
  // Mode register field positions.
  localparam int MODE_CKS_LSB = 14;
  localparam int MODE_COUNT_CLOCK_SOURCE_BIT = 12;
  localparam int MODE_MAS_BIT = 11;
  localparam int MODE_STS_LSB = 8;
  localparam int MODE_COS_LSB = 6;
  localparam int MODE_MD_LSB = 1;
  localparam int MODE_MD0_BIT = 0;
  localparam logic [15:0] MODE_WMASK = 16'hDFCF;
  // Trigger register bits.
  localparam int TRIG_START_BIT = 0;
  localparam int TRIG_STOP_BIT = 1;
  // Status register bits.
  localparam int STAT_EN_BIT = 0;
  localparam int STAT_RUN_BIT = 1;
  // Field encodings.
  localparam logic [1:0] EDGE_LOW_WIDTH = 2'h2;
  localparam logic [1:0] EDGE_HIGH_WIDTH = 2'h3;
  localparam logic [2:0] STS_INPUT_EDGE = 3'h2;
  localparam logic [3:0] MD_ONE_COUNT = 4'h4;
  // Reset values, plus the counter terminal and rest values.
  localparam logic [15:0] MODE_RESET = 16'h0000;
  localparam logic [1:0] EDGE_RESET = 2'h0;
  localparam logic [15:0] DATA_RESET = 16'h0000;
  localparam logic [15:0] CNT_RESET = 16'h0000;
  localparam logic [15:0] CNT_TERMINAL = 16'h0000;
  localparam logic [15:0] CNT_STOP_VALUE = 16'hFFFF;
  // Prescaler exponents for the four operation clocks, prescaler field widths and AXI response codes.
  localparam logic [15:0] PRESC_RESET = 16'h6420;
  localparam int PRESC_FIELD_W = 4;
  localparam int PRESC_W = 16;
  localparam logic [1:0] AXI_OKAY = 2'h0;
  localparam logic [1:0] AXI_SLVERR = 2'h2;
  typedef enum logic [2:0] {
    IWO_IDLE = 3'b001,
    IWO_WAIT = 3'b010,
    IWO_COUNT = 3'b100
  } iwo_state_t;
endpackage

// File: iwo_prescaler.sv
`timescale 1ns/1ps
module iwo_prescaler
  import iwo_pkg::*;
(
  input wire logic clk_i, // System clock.
  input wire logic rst_n_i, // Synchronous reset, active low.
  input wire logic ce_i, // Clock enable.
  input wire logic [15:0] presc_i, // Four 4-bit divide exponents.
  output logic [3:0] tick_o // One tick per operation clock.
);
  logic [PRESC_W-1:0] div_reg;

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      div_reg <= '0;
    end else if (ce_i) begin
      div_reg <= div_reg + 16'h0001;
    end
  end

  // A tick fires when all bits below the exponent are ones, giving a 2^k divide.
  genvar g;
  generate
    for (g = 0; g < 4; g++) begin : g_tick
      logic [PRESC_W-1:0] mask;
      assign mask = (16'h0001 << presc_i[g*PRESC_FIELD_W +: PRESC_FIELD_W]) - 16'h0001;
      assign tick_o[g] = ce_i && ((div_reg & mask) == mask);
    end
  endgenerate
endmodule

// File: iwo_edge_detect.sv
`timescale 1ns/1ps
module iwo_edge_detect
  import iwo_pkg::*;
(
  input wire logic clk_i, // System clock.
  input wire logic rst_n_i, // Synchronous reset, active low.
  input wire logic ce_i, // Clock enable.
  input wire logic tick_i, // Operation clock tick.
  input wire logic timer_input_i, // Monitored input.
  output logic rise_o, // Rising edge seen on this tick.
  output logic fall_o // Falling edge seen on this tick.
);
  logic samp_reg;
  logic prev_reg;

  // The input is sampled once per operation clock, so edges resolve to one tick.
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      samp_reg <= 1'b0;
      prev_reg <= 1'b0;
    end else if (ce_i && tick_i) begin
      samp_reg <= timer_input_i;
      prev_reg <= samp_reg;
    end
  end

  assign rise_o = samp_reg && !prev_reg;
  assign fall_o = !samp_reg && prev_reg;
endmodule

// File: iwo_timer_props.sv
`timescale 1ns/1ps
module iwo_timer_props
  import iwo_pkg::*;
(
  input wire logic clk_i, // Clock.
  input wire logic rst_n_i, // Reset, active low.
  input wire logic ce_i, // Clock enable.
  input wire logic s_axi_bvalid, // Write response valid.
  input wire logic s_axi_bready, // Write response ready.
  input wire logic s_axi_arvalid, // Read address valid.
  input wire logic s_axi_arready, // Read address ready.
  input wire logic [31:0] s_axi_rdata, // Read data.
  input wire logic s_axi_rvalid, // Read data valid.
  input wire logic s_axi_rready, // Read data ready.
  input wire logic timer_output_pin_o, // Unused channel output.
  input wire logic channel_interrupt_o // Interrupt pulse.
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  // A second interrupt needs a full reload count, so eight quiet cycles are a safe floor.
  property p_irq_gap; ce_i && channel_interrupt_o |=> !channel_interrupt_o [*8]; endproperty
  a_irq_gap: assert property (p_irq_gap) else $error("interrupt is not a lone pulse");
  property p_pin_idle; timer_output_pin_o == 1'h0; endproperty
  a_pin_idle: assert property (p_pin_idle) else $error("channel output pin driven");
  property p_b_hold; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid; endproperty
  a_b_hold: assert property (p_b_hold) else $error("write response dropped early");
  property p_b_clear; ce_i && s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid; endproperty
  a_b_clear: assert property (p_b_clear) else $error("write response repeated");
  property p_r_hold; s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata); endproperty
  a_r_hold: assert property (p_r_hold) else $error("read data not held");
  property p_r_answer; ce_i && s_axi_arvalid && s_axi_arready |=> s_axi_rvalid; endproperty
  a_r_answer: assert property (p_r_answer) else $error("read answer late");
  property p_r_clear; ce_i && s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid; endproperty
  a_r_clear: assert property (p_r_clear) else $error("read answer repeated");
  property p_ar_block; s_axi_rvalid |-> !s_axi_arready; endproperty
  a_ar_block: assert property (p_ar_block) else $error("read address taken while busy");
  property p_ar_freeze; !ce_i |-> !s_axi_arready; endproperty
  a_ar_freeze: assert property (p_ar_freeze) else $error("read address ready while frozen");
  c_irq: cover property (channel_interrupt_o);
  c_read: cover property (s_axi_rvalid && s_axi_rready);
  c_write: cover property (s_axi_bvalid && s_axi_bready);
endmodule
bind iwo_timer iwo_timer_props u_props (.clk_i(clk_i), .rst_n_i(rst_n_i), .ce_i(ce_i), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
  .timer_output_pin_o(timer_output_pin_o), .channel_interrupt_o(channel_interrupt_o));

// File: iwo_input_model.sv
`timescale 1ns/1ps
module iwo_input_model (
  input wire logic clk_i, // Clock.
  input wire logic rst_n_i, // Reset, active low.
  input wire logic go_i, // Launch one pulse.
  input wire logic high_i, // Active level of the pulse.
  input wire logic [19:0] width_i, // Pulse width in clock cycles.
  output logic busy_o, // Pulse in progress.
  output logic timer_input_o // Pin level.
);
  logic [19:0] left_reg;
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) left_reg <= 20'h00000;
    else if (go_i && !busy_o) left_reg <= width_i;
    else if (busy_o) left_reg <= left_reg - 20'h00001;
  end
  assign busy_o = left_reg != 20'h00000;
  // The pin is always driven; between pulses it rests at the inactive level.
  assign timer_input_o = busy_o ? high_i : !high_i;
endmodule

// File: tb_top.sv
`timescale 1ns/1ps
`define CHK(n, e, g) begin total_checks++; if ((g) !== (e)) begin errors++; \
  $display("mismatch %s expected %h seen %h", n, e, g); end end
module tb_top;
  import iwo_pkg::*;
  logic clk_i = 1'h0, rst_n_i = 1'h0, ce_i = 1'h1, go = 1'h0, hi = 1'h1;
  logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h00000000;
  logic [19:0] width = 20'h00000;
  logic awready, wready, bvalid, arready, rvalid, tout, irq, tin, busy;
  logic [1:0] bresp, rresp, r;
  logic [31:0] rdata, v, w;
  logic [31:0] bad [3] = '{32'h0000020A, 32'h00000308, 32'h00001208};
  int errors = 0, total_checks = 0, irqs = 0, d;
  iwo_timer dut (.clk_i(clk_i), .rst_n_i(rst_n_i), .ce_i(ce_i), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .timer_input_i(tin), .timer_output_pin_o(tout), .channel_interrupt_o(irq));
  iwo_input_model pin (.clk_i(clk_i), .rst_n_i(rst_n_i), .go_i(go), .high_i(hi), .width_i(width), .busy_o(busy),
    .timer_input_o(tin));
  initial begin
    forever #20 clk_i = ~clk_i;
  end
  always @(posedge clk_i) begin
    if (irq === 1'h1) irqs++;
  end
  task automatic summarize;
    $display("checks %0d mismatches %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  task automatic hang;
    errors++;
    $display("wait limit reached");
    summarize();
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] dt, output logic [1:0] rs);
    int n;
    n = 0;
    @(posedge clk_i);
    awaddr <= a;
    wdata <= dt;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= 1'h1;
    while (n < 50) begin
      @(posedge clk_i);
      n++;
      if (awready === 1'h1) awvalid <= 1'h0;
      if (wready === 1'h1) wvalid <= 1'h0;
      if (bvalid === 1'h1) begin
        bready <= 1'h0;
        rs = bresp;
        n = 100;
      end
    end
    if (n < 100) hang();
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] dt, output logic [1:0] rs);
    int n;
    n = 0;
    @(posedge clk_i);
    araddr <= a;
    arvalid <= 1'h1;
    rready <= 1'h1;
    while (n < 50) begin
      @(posedge clk_i);
      n++;
      if (arready === 1'h1) arvalid <= 1'h0;
      if (rvalid === 1'h1) begin
        rready <= 1'h0;
        dt = rdata;
        rs = rresp;
        n = 100;
      end
    end
    if (n < 100) hang();
  endtask
  task automatic chk(input logic [7:0] a, input logic [31:0] e, input string n);
    logic [31:0] x;
    logic [1:0] s;
    rd(a, x, s);
    `CHK(n, e, x)
  endtask
  task automatic launch(input logic h, input logic [19:0] n);
    @(posedge clk_i);
    hi <= h;
    width <= n;
    go <= 1'h1;
    @(posedge clk_i);
    go <= 1'h0;
    @(posedge clk_i);
  endtask
  // Waits out the pulse, then lets the two-flop edge detector catch the closing edge.
  task automatic settle(input int n);
    int i;
    i = 0;
    while (busy === 1'h1 && i < 70000) begin
      @(posedge clk_i);
      i++;
    end
    if (i >= 70000) hang();
    repeat (n) @(posedge clk_i);
  endtask
  initial begin
    repeat (16) @(posedge clk_i);
    rst_n_i <= 1'h1;
    chk(ADDR_STAT, 32'h00000000, "status");
    chk(ADDR_PRESC, {16'h0000, PRESC_RESET}, "prescaler");
    rd(8'h1C, v, r);
    `CHK("unmapped read", AXI_SLVERR, r)
    wr(8'h1C, 32'h00000001, r);
    `CHK("unmapped write", AXI_SLVERR, r)
    $display("test reset done");
    wr(ADDR_MODE, 32'h0000FFFF, r);
    chk(ADDR_MODE, {16'h0000, MODE_WMASK}, "mode mask");
    wr(ADDR_MODE, 32'h00000208, r);
    wr(ADDR_DATA, 32'h0000FFFF, r);
    wr(ADDR_EDGE, 32'h00000003, r);
    wr(ADDR_TRIG, 32'h00000001, r);
    chk(ADDR_STAT, 32'h00000001, "enable");
    chk(ADDR_TRIG, 32'h00000000, "trigger clear");
    $display("test start done");
    for (int k = 0; k < 4; k++) begin
      wr(ADDR_MODE, 32'h00000208 | (32'(k) << MODE_CKS_LSB), r);
      launch(1'h1, 20'h00280);
      if (k == 0) begin
        repeat (100) @(posedge clk_i);
        rd(ADDR_CNT, v, r);
        rd(ADDR_CNT, w, r);
        `CHK("running", 1'h1, w < v)
      end
      settle(200);
      rd(ADDR_CNT, v, r);
      chk(ADDR_CNT, v, "held");
      d = 32'h0000FFFF - v;
      `CHK("high width", 1'h1, d + 3 >= (640 >> (2 * k)) && d <= (640 >> (2 * k)) + 3)
    end
    `CHK("start interrupt", 0, irqs)
    $display("test high width done");
    wr(ADDR_MODE, 32'h00000208, r);
    wr(ADDR_EDGE, 32'h00000002, r);
    launch(1'h0, 20'h0012C);
    settle(20);
    rd(ADDR_CNT, v, r);
    d = 32'h0000FFFF - v;
    `CHK("low width", 1'h1, d + 3 >= 300 && d <= 303)
    wr(ADDR_EDGE, 32'h00000003, r);
    foreach (bad[i]) begin
      wr(ADDR_MODE, bad[i], r);
      rd(ADDR_CNT, v, r);
      launch(1'h1, 20'h0012C);
      settle(20);
      chk(ADDR_CNT, v, "ignored start");
    end
    $display("test modes done");
    wr(ADDR_MODE, 32'h00000208, r);
    launch(1'h1, 20'h000C8);
    wr(ADDR_EDGE, 32'h00000002, r);
    settle(20);
    rd(ADDR_CNT, v, r);
    d = 32'h0000FFFF - v;
    `CHK("no restart", 1'h1, d >= 200)
    wr(ADDR_EDGE, 32'h00000003, r);
    launch(1'h1, 20'h007D0);
    repeat (300) @(posedge clk_i);
    rd(ADDR_CNT, v, r);
    @(posedge clk_i);
    ce_i <= 1'h0;
    repeat (100) @(posedge clk_i);
    ce_i <= 1'h1;
    rd(ADDR_CNT, w, r);
    `CHK("frozen", 1'h1, v - w < 20)
    wr(ADDR_TRIG, 32'h00000002, r);
    chk(ADDR_STAT, 32'h00000000, "stopped");
    rd(ADDR_CNT, v, r);
    repeat (100) @(posedge clk_i);
    chk(ADDR_CNT, v, "stop holds");
    settle(20);
    $display("test stop done");
    wr(ADDR_TRIG, 32'h00000001, r);
    launch(1'h1, 20'h10190);
    settle(200);
    `CHK("interrupt", 1, irqs)
    chk(ADDR_CNT, {16'h0000, CNT_STOP_VALUE}, "rest value");
    $display("test overflow done");
    summarize();
  end
endmodule
